// [plp_delay_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module plp_delay_timer
   import plp_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Settings, in processing intervals
   input  wire logic [TMR_W-1:0] pickupCnt,
   input  wire logic [TMR_W-1:0] dropoutCnt,
   // Input and output
   input  wire logic             inA,
   output logic                  outB
);
   // ---------------------------------------------------------------
   // Pickup and dropout counting
   // ---------------------------------------------------------------
   logic [TMR_W-1:0] count;
   logic [TMR_W-1:0] next_count;
   logic             state;
   logic             next_state;

   always_comb begin
      next_count = CNT_ZERO;
      next_state = state;
      if (!state) begin
         if (inA) begin
            if (count + CNT_ONE >= pickupCnt) begin
               next_state = 1'b1;
            end else begin
               next_count = count + CNT_ONE;
            end
         end
      end else begin
         if (!inA) begin
            if (count + CNT_ONE >= dropoutCnt) begin
               next_state = 1'b0;
            end else begin
               next_count = count + CNT_ONE;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         count <= CNT_ZERO;
         state <= BIT_RST;
      end else begin
         count <= next_count;
         state <= next_state;
      end
   end

   // Combinational so zero settings act in the same interval
   always_comb begin
      if (!state) begin
         outB = inA && (pickupCnt == CNT_ZERO);
      end else begin
         outB = !(!inA && (dropoutCnt == CNT_ZERO));
      end
   end
endmodule
`default_nettype wire

// [plp_pkg.sv]
package plp_pkg;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int CMP_W = 16;
   localparam int TMR_W = 16;
   // ---------------------------------------------------------------
   // Reset values and counter steps
   // ---------------------------------------------------------------
   localparam logic [TMR_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [TMR_W-1:0] CNT_ONE  = 16'h0001;
   localparam logic             BIT_RST  = 1'h0;
   // Edge timer phases
   typedef enum logic [1:0] {
      PLP_IDLE,
      PLP_DELAY,
      PLP_PULSE
   } plp_edge_t;
endpackage

// [plp_primitives.sv]
// Notes on behaviour
// - Comparator high only when A exceeds B
// - XOR high when inputs differ
// - NOR high when no input asserted
// - AND needs all; OR needs any
// - AND with inverted second input
// - NAND high when any input low
// - Delay timer picks up after full delay
// - Zero pickup: output rises same interval
// - Zero dropout: output falls same interval
// - Edge timer starts on rising edge
// - Edge timer pulse lasts configured duration
// - Zero pulse duration gives one interval
// - Edge timer ignores input while running
// - Latch sets on S, clears on R
// - Falling edge gives one-interval pulse
`timescale 1ns/1ns
`default_nettype none
module plp_primitives
   import plp_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Comparator
   input  wire logic [CMP_W-1:0] cmpA,
   input  wire logic [CMP_W-1:0] cmpB,
   output logic                  cmpOut,
   // Gates
   input  wire logic             gateA,
   input  wire logic             gateB,
   output logic                  orOut,
   output logic                  xorOut,
   output logic                  norOut,
   output logic                  andOut,
   output logic                  andInvOut,
   output logic                  nandOut,
   // Delay timer
   input  wire logic [TMR_W-1:0] dlyPickup,
   input  wire logic [TMR_W-1:0] dlyDropout,
   input  wire logic             dlyIn,
   output logic                  dlyOut,
   // Edge trigger timer
   input  wire logic [TMR_W-1:0] edgDelay,
   input  wire logic [TMR_W-1:0] edgPulse,
   input  wire logic             edgIn,
   output logic                  edgOut,
   // Set/reset latch
   input  wire logic             latSet,
   input  wire logic             latReset,
   output logic                  latOut,
   // Falling edge detector
   input  wire logic             fallIn,
   output logic                  fallOut
);
   // ---------------------------------------------------------------
   // Comparator and gates
   // ---------------------------------------------------------------
   logic next_cmpOut;
   logic next_orOut;
   logic next_xorOut;
   logic next_norOut;
   logic next_andOut;
   logic next_andInvOut;
   logic next_nandOut;

   always_comb begin
      next_cmpOut    = cmpA > cmpB;
      next_orOut     = gateA | gateB;
      next_xorOut    = gateA ^ gateB;
      next_norOut    = ~(gateA | gateB);
      next_andOut    = gateA & gateB;
      next_andInvOut = gateA & ~gateB;
      next_nandOut   = ~(gateA & gateB);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cmpOut    <= BIT_RST;
         orOut     <= BIT_RST;
         xorOut    <= BIT_RST;
         norOut    <= BIT_RST;
         andOut    <= BIT_RST;
         andInvOut <= BIT_RST;
         nandOut   <= BIT_RST;
      end else begin
         cmpOut    <= next_cmpOut;
         orOut     <= next_orOut;
         xorOut    <= next_xorOut;
         norOut    <= next_norOut;
         andOut    <= next_andOut;
         andInvOut <= next_andInvOut;
         nandOut   <= next_nandOut;
      end
   end

   // ---------------------------------------------------------------
   // Delay timer
   // ---------------------------------------------------------------
   logic dlyRaw;

   plp_delay_timer uDelay (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .pickupCnt  (dlyPickup),
      .dropoutCnt (dlyDropout),
      .inA        (dlyIn),
      .outB       (dlyRaw)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         dlyOut <= BIT_RST;
      end else begin
         dlyOut <= dlyRaw;
      end
   end

   // ---------------------------------------------------------------
   // Edge trigger timer
   // ---------------------------------------------------------------
   plp_edge_t        edgState;
   plp_edge_t        next_edgState;
   logic [TMR_W-1:0] edgCount;
   logic [TMR_W-1:0] next_edgCount;
   logic             edgPrev;
   logic             next_edgOut;

   always_comb begin
      next_edgState = edgState;
      next_edgCount = edgCount;
      next_edgOut   = 1'b0;
      case (edgState)
         PLP_IDLE: begin
            next_edgCount = CNT_ZERO;
            if (edgIn && !edgPrev) begin
               if (edgDelay == CNT_ZERO) begin
                  next_edgState = PLP_PULSE;
                  next_edgOut   = 1'b1;
               end else begin
                  next_edgState = PLP_DELAY;
                  next_edgCount = CNT_ONE;
               end
            end
         end
         PLP_DELAY: begin
            if (edgCount >= edgDelay) begin
               next_edgState = PLP_PULSE;
               next_edgCount = CNT_ZERO;
               next_edgOut   = 1'b1;
            end else begin
               next_edgCount = edgCount + CNT_ONE;
            end
         end
         PLP_PULSE: begin
            if (edgCount + CNT_ONE >= edgPulse) begin
               next_edgState = PLP_IDLE;
               next_edgCount = CNT_ZERO;
            end else begin
               next_edgCount = edgCount + CNT_ONE;
               next_edgOut   = 1'b1;
            end
         end
         default: begin
            next_edgState = PLP_IDLE;
            next_edgCount = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         edgState <= PLP_IDLE;
         edgCount <= CNT_ZERO;
         edgPrev  <= BIT_RST;
         edgOut   <= BIT_RST;
      end else begin
         edgState <= next_edgState;
         edgCount <= next_edgCount;
         edgPrev  <= edgIn;
         edgOut   <= next_edgOut;
      end
   end

   // ---------------------------------------------------------------
   // Latch and falling edge
   // ---------------------------------------------------------------
   logic next_latOut;
   logic fallPrev;
   logic next_fallOut;

   always_comb begin
      if (latReset) begin
         next_latOut = 1'b0;
      end else if (latSet) begin
         next_latOut = 1'b1;
      end else begin
         next_latOut = latOut;
      end
      next_fallOut = fallPrev && !fallIn;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         latOut   <= BIT_RST;
         fallPrev <= BIT_RST;
         fallOut  <= BIT_RST;
      end else begin
         latOut   <= next_latOut;
         fallPrev <= fallIn;
         fallOut  <= next_fallOut;
      end
   end
endmodule
`default_nettype wire

// [plp_primitives_props.sv]
`timescale 1ns/1ns
`default_nettype none
module plp_primitives_props
   import plp_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Inputs
   input  wire logic [CMP_W-1:0] cmpA,
   input  wire logic [CMP_W-1:0] cmpB,
   input  wire logic [TMR_W-1:0] dlyPickup,
   input  wire logic [TMR_W-1:0] dlyDropout,
   input  wire logic [TMR_W-1:0] edgPulse,
   input  wire logic             gateA,
   input  wire logic             gateB,
   input  wire logic             dlyIn,
   input  wire logic             latSet,
   input  wire logic             latReset,
   input  wire logic             fallIn,
   // Outputs
   input  wire logic             cmpOut,
   input  wire logic             orOut,
   input  wire logic             xorOut,
   input  wire logic             norOut,
   input  wire logic             andOut,
   input  wire logic             andInvOut,
   input  wire logic             nandOut,
   input  wire logic             dlyOut,
   input  wire logic             edgOut,
   input  wire logic             latOut,
   input  wire logic             fallOut
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   sequence s_live;
      $past(rst_b);
   endsequence
   sequence s_fall;
      fallIn ##1 !fallIn;
   endsequence
   a_cmp_greater: assert property (s_live |->
      cmpOut == ($past(cmpA) > $past(cmpB))) else $error("cmp wrong");
   a_xor_gate: assert property (s_live |->
      xorOut == ($past(gateA) ^ $past(gateB))) else $error("xor wrong");
   a_nor_gate: assert property (s_live |->
      norOut == !($past(gateA) | $past(gateB))) else $error("nor wrong");
   a_and_or: assert property (s_live |->
      andOut == ($past(gateA) & $past(gateB)) &&
      orOut == ($past(gateA) | $past(gateB))) else $error("and/or wrong");
   a_and_inv: assert property (s_live |->
      andInvOut == ($past(gateA) & !$past(gateB))) else $error("andinv");
   a_nand_gate: assert property (s_live |->
      nandOut == !($past(gateA) & $past(gateB))) else $error("nand wrong");
   a_dly_zero: assert property ($past(rst_b) &&
      dlyPickup == 16'h0000 && dlyDropout == 16'h0000 &&
      $stable(dlyPickup) && $stable(dlyDropout)
      |=> dlyOut == $past(dlyIn)) else $error("zero delay wrong");
   a_edge_hold: assert property ($rose(edgOut) &&
      edgPulse == 16'h0003 |-> edgOut[*3] ##1 !edgOut) else $error("pulse");
   a_edge_short: assert property ($rose(edgOut) &&
      edgPulse == 16'h0000 |=> !edgOut) else $error("short pulse");
   a_lat_clear: assert property (latReset |=> !latOut)
      else $error("latch not cleared");
   a_lat_hold: assert property (!latReset && (latSet || latOut)
      |=> latOut) else $error("latch lost");
   a_fall_pulse: assert property (s_fall |=> fallOut)
      else $error("fall missed");
   a_fall_only: assert property (fallOut |->
      $past(fallIn, 2) && !$past(fallIn)) else $error("fall spurious");
endmodule
bind plp_primitives plp_primitives_props u_props (.*);
`default_nettype wire

// [plp_sink.sv]
`timescale 1ns/1ns
`default_nettype none
module plp_sink (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Trip pulse from the edge timer
   input  wire logic       trip,
   output logic      [3:0] tripCnt
);
   logic prev;
   // Counts trip pulses seen downstream
   always_ff @(posedge clk_sys) begin
      prev    <= rst_b & trip;
      tripCnt <= !rst_b ? 4'h0 : tripCnt + 4'(trip & !prev);
   end
endmodule
`default_nettype wire

// [test_protection_logic_primitives.sv]
`timescale 1ns/1ns
`default_nettype none
module test_protection_logic_primitives;
   import plp_pkg::*;
   logic             clk_sys = 1'h0, rst_b = 1'h0;
   logic [CMP_W-1:0] cmpA = 16'h0000, cmpB = 16'h0000;
   logic [TMR_W-1:0] dlyPickup = 16'h0003, dlyDropout = 16'h0002;
   logic [TMR_W-1:0] edgDelay = 16'h0002, edgPulse = 16'h0003;
   logic gateA = 1'h0, gateB = 1'h0, dlyIn = 1'h0, edgIn = 1'h0;
   logic latSet = 1'h0, latReset = 1'h0, fallIn = 1'h0;
   logic orOut, xorOut, norOut, andOut, andInvOut, nandOut;
   logic cmpOut, dlyOut, edgOut, latOut, fallOut;
   logic [3:0] tripCnt;
   int   num_errors = 0, cmp_count = 0, cycles = 0;
   plp_primitives dut (.*);
   plp_sink u_sink (.clk_sys, .rst_b, .trip(edgOut), .tripCnt);
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 1000) begin
         num_errors++;
         final_report();
      end
   end
   task chk(input string n, input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %b got %b", n, e, s);
      end
   endtask
   task final_report;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task test_gates;
      logic a, b;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         {gateA, gateB} <= 2'(i);
         cmpA <= 16'h8000;
         cmpB <= 16'h7fff + 16'(i % 3);
         #1;
         a = ((i - 1) & 2) != 0;
         b = ((i - 1) & 1) != 0;
         if (i > 0) begin
            chk("cmpOut", (i - 1) % 3 == 0, cmpOut);
            chk("xorOut", a ^ b, xorOut);
            chk("norOut", !(a | b), norOut);
            chk("andOut", a & b, andOut);
            chk("orOut", a | b, orOut);
            chk("andInvOut", a & !b, andInvOut);
            chk("nandOut", !(a & b), nandOut);
         end
      end
   endtask
   task test_delay;
      @(posedge clk_sys) dlyIn <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys) #1 chk("dlyOut", i == 3, dlyOut);
      end
      @(posedge clk_sys) dlyIn <= 1'h0;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys) #1 chk("dlyOut", i < 2, dlyOut);
      end
      @(posedge clk_sys) dlyIn <= 1'h1;
      @(posedge clk_sys) dlyIn <= 1'h0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys) #1 chk("dlyOut", 1'h0, dlyOut);
      end
      @(posedge clk_sys) {dlyPickup, dlyDropout} <= 32'h0000_0000;
      @(posedge clk_sys) dlyIn <= 1'h1;
      @(posedge clk_sys) #1 chk("dlyOut", 1'h1, dlyOut);
      @(posedge clk_sys) dlyIn <= 1'h0;
      @(posedge clk_sys) #1 chk("dlyOut", 1'h0, dlyOut);
   endtask
   task test_edge;
      @(posedge clk_sys) edgIn <= 1'h1;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys) edgIn <= i >= 2;
         #1 chk("edgOut", i >= 2 && i < 5, edgOut);
      end
      @(posedge clk_sys) {edgDelay, edgPulse} <= 32'h0000_0000;
      edgIn <= 1'h0;
      @(posedge clk_sys) edgIn <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys) #1 chk("edgOut", i == 0, edgOut);
      end
      cmp_count++;
      if (tripCnt !== 4'h2) begin
         num_errors++;
         $display("MISMATCH tripCnt exp 2 got %0d", tripCnt);
      end
   endtask
   task test_latch;
      logic [1:0] p;
      logic       e;
      e = 1'h0;
      for (int i = 0; i < 8; i++) begin
         p = 2'(14'h0632 >> (2 * i));
         @(posedge clk_sys) {latSet, latReset} <= p;
         #1 chk("latOut", e, latOut);
         e = !p[0] && (p[1] || e);
      end
   endtask
   task test_fall;
      logic prev, cur;
      prev = 1'h0;
      cur = 1'h0;
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_sys) fallIn <= 1'(8'h26 >> i);
         #1 chk("fallOut", prev && !cur, fallOut);
         prev = cur;
         cur = 1'(8'h26 >> i);
      end
   endtask
   task test_reset;
      @(posedge clk_sys) {latSet, edgIn} <= 2'h2;
      @(posedge clk_sys) latSet <= 1'h0;
      @(posedge clk_sys) rst_b <= 1'h0;
      #1 chk("latOut", 1'h1, latOut);
      @(posedge clk_sys) #1 chk("latOut", 1'h0, latOut);
      chk("nandOut", 1'h0, nandOut);
      @(posedge clk_sys) rst_b <= 1'h1;
      @(posedge clk_sys) #1 chk("nandOut", 1'h1, nandOut);
      chk("latOut", 1'h0, latOut);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'h1;
      test_gates();
      test_delay();
      test_edge();
      test_latch();
      test_fall();
      test_reset();
      final_report();
   end
endmodule
`default_nettype wire
